/* File: pfl_pkg.sv */
package pfl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PROG_MIN_NS = 500;
  // least time, so round up
  localparam int unsigned PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_CYC = 64;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned MIN_ADDR_W = 17;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RATE_W = 4;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned HALF_W = 8;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  // half period of the slowest rate, in clk cycles
  localparam logic [7:0] SLOW_HALF = 8'h30;
  // capture reads synchronised data, so a half period needs three cycles
  localparam logic [7:0] FAST_HALF_MIN = 8'h03;
  localparam logic [3:0] RATE_LOWEST = 4'h1;
  localparam logic [3:0] RATE_MAX = 4'hC;
  localparam logic [3:0] BIT_COUNT = 4'h8;

  typedef enum logic [2:0] {
    PFL_IDLE  = 3'b000,
    PFL_CLEAR = 3'b001,
    PFL_WAIT  = 3'b011,
    PFL_LOAD  = 3'b010,
    PFL_DONE  = 3'b110,
    PFL_FAIL  = 3'b111
  } pfl_state_e;

  // pin levels for the flash control lines
  typedef struct packed {
    logic chip_enable;
    logic output_enable;
    logic write_enable;
  } pfl_flash_ctl_s;

  // status levels from the configuration engine
  typedef struct packed {
    logic crc_error;
    logic load_end;
    logic rate_valid;
  } pfl_cfg_status_s;
endpackage

/* File: pfl_loader.sv */
// Functional notes
// - config clock from internal oscillator, driven out
// - start slowest, speed up on requested rate
// - fetch at config rate, serialise eight-fold faster
// - init low while clearing configuration memory
// - release init, sample mode pins then
// - crc mismatch drives init low
// - done low while loading, released on success
// - program pulse of 500 ns restarts configuration
// - program low puts I/O pins high-impedance
// - drive 24 address lines, low ones suffice
// - one address per byte, step per byte
// - clock pin user I/O after done unless kept
// - address changes on falling config clock
// - data captured on rising config clock
// - chip and output enable low while loading
// - write enable high while loading
module pfl_loader #(
  parameter int unsigned ADDR_BITS = pfl_pkg::ADDR_W,
  parameter int unsigned FIFO_DEPTH = 2,
  parameter int unsigned CLEAR_CYCLES = pfl_pkg::CLEAR_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serialiser clock, eight times the config clock
  input wire logic cfg_shift_clk,
  // board control pins
  input wire logic program_request_n,
  input wire logic [pfl_pkg::MODE_W-1:0] mode_pins,
  input wire logic keep_interface,
  input wire logic init_in,
  output logic init_out,
  output logic init_oe_n,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe_n,
  // configuration clock pin
  output logic config_clock_out,
  output logic config_clock_oe_n,
  // flash pins
  output logic [ADDR_BITS-1:0] flash_addr,
  output logic flash_addr_oe_n,
  output pfl_pkg::pfl_flash_ctl_s flash_ctl,
  output logic flash_ctl_oe_n,
  input wire logic [pfl_pkg::BYTE_W-1:0] flash_data_in,
  // configuration engine, cfg_shift_clk domain
  input wire pfl_pkg::pfl_cfg_status_s cfg_status,
  input wire logic [pfl_pkg::RATE_W-1:0] config_clock_rate_setting,
  input wire logic cfg_ready,
  output logic cfg_bit,
  output logic cfg_bit_valid,
  // status
  output logic [pfl_pkg::MODE_W-1:0] mode_latched,
  output logic loading
);
  localparam int unsigned PW = $clog2(FIFO_DEPTH);

  if (ADDR_BITS < pfl_pkg::MIN_ADDR_W || ADDR_BITS > pfl_pkg::ADDR_W) begin : g_bad_addr
    $error("ADDR_BITS out of range");
  end
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end
  // the clearing counter is 16 bits wide
  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES > 65536) begin : g_bad_clear
    $error("CLEAR_CYCLES must be between 1 and 65536");
  end

  function automatic logic [pfl_pkg::HALF_W-1:0] half_of(
    input logic [pfl_pkg::RATE_W-1:0] rate
  );
    logic [pfl_pkg::HALF_W-1:0] h;
    h = pfl_pkg::SLOW_HALF;
    if (rate > pfl_pkg::RATE_LOWEST)
      h = pfl_pkg::SLOW_HALF / {4'h0, rate};
    if (h < pfl_pkg::FAST_HALF_MIN)
      h = pfl_pkg::FAST_HALF_MIN;
    return h;
  endfunction

  // two-flop synchronisers for pins and the other domain
  logic [1:0] prog_sy_q, init_sy_q, done_sy_q, keep_sy_q;
  logic [pfl_pkg::MODE_W-1:0] mode_sy1_q, mode_sy2_q;
  logic [pfl_pkg::BYTE_W-1:0] data_sy1_q, data_sy2_q;
  pfl_pkg::pfl_cfg_status_s st_sy1_q, st_sy2_q;
  logic [pfl_pkg::RATE_W-1:0] rate_sy1_q, rate_sy2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_sy_q <= 2'h0;
      init_sy_q <= 2'h0;
      done_sy_q <= 2'h0;
      keep_sy_q <= 2'h0;
      mode_sy1_q <= '0;
      mode_sy2_q <= '0;
      data_sy1_q <= '0;
      data_sy2_q <= '0;
      st_sy1_q <= '0;
      st_sy2_q <= '0;
      rate_sy1_q <= '0;
      rate_sy2_q <= '0;
    end else begin
      prog_sy_q <= {prog_sy_q[0], program_request_n};
      init_sy_q <= {init_sy_q[0], init_in};
      done_sy_q <= {done_sy_q[0], done_in};
      keep_sy_q <= {keep_sy_q[0], keep_interface};
      mode_sy1_q <= mode_pins;
      mode_sy2_q <= mode_sy1_q;
      data_sy1_q <= flash_data_in;
      data_sy2_q <= data_sy1_q;
      st_sy1_q <= cfg_status;
      st_sy2_q <= st_sy1_q;
      rate_sy1_q <= config_clock_rate_setting;
      rate_sy2_q <= rate_sy1_q;
    end
  end
  wire prog_hi = prog_sy_q[1];

  // program pulse width
  logic [7:0] plow_q, plow_d;
  wire prog_armed = (plow_q >= 8'(pfl_pkg::PROG_MIN_CYC));
  assign plow_d = prog_hi ? 8'h00 : (prog_armed ? plow_q : plow_q + 8'h01);

  // state machine
  pfl_pkg::pfl_state_e state_q, state_d;
  logic [15:0] clr_q;
  wire clr_end = (clr_q == 16'(CLEAR_CYCLES - 1));
  logic [pfl_pkg::HALF_W-1:0] half_q, hcnt_q;
  logic config_clock_out_q;
  logic [ADDR_BITS-1:0] addr_q;
  logic [PW:0] cnt_q;
  wire fifo_full = (cnt_q == (PW+1)'(FIFO_DEPTH));
  wire in_load = (state_q == pfl_pkg::PFL_LOAD);
  wire tick = in_load && (hcnt_q == '0);
  // hold the clock low while the buffer is full, so no byte is dropped
  wire rise = tick && !config_clock_out_q && !fifo_full;
  wire fall = tick && config_clock_out_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pfl_pkg::PFL_IDLE:  if (prog_hi) state_d = pfl_pkg::PFL_CLEAR;
      pfl_pkg::PFL_CLEAR: if (clr_end) state_d = pfl_pkg::PFL_WAIT;
      pfl_pkg::PFL_WAIT:  if (init_sy_q[1]) state_d = pfl_pkg::PFL_LOAD;
      pfl_pkg::PFL_LOAD: begin
        if (st_sy2_q.crc_error)
          state_d = pfl_pkg::PFL_FAIL;
        else if (st_sy2_q.load_end)
          state_d = pfl_pkg::PFL_DONE;
      end
      pfl_pkg::PFL_DONE:  state_d = pfl_pkg::PFL_DONE;
      pfl_pkg::PFL_FAIL:  state_d = pfl_pkg::PFL_FAIL;
      default:            state_d = pfl_pkg::PFL_IDLE;
    endcase
    if (prog_armed)
      state_d = pfl_pkg::PFL_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= pfl_pkg::PFL_IDLE;
      plow_q <= 8'h00;
      clr_q <= 16'h0000;
      mode_latched <= '0;
    end else begin
      state_q <= state_d;
      plow_q <= plow_d;
      clr_q <= (state_q == pfl_pkg::PFL_CLEAR) ? clr_q + 16'h0001 : 16'h0000;
      if (state_q == pfl_pkg::PFL_CLEAR && clr_end)
        mode_latched <= mode_sy2_q;
    end
  end

  // config clock divider and flash address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_q <= pfl_pkg::SLOW_HALF;
      hcnt_q <= pfl_pkg::SLOW_HALF;
      config_clock_out_q <= 1'b0;
      addr_q <= ADDR_BITS'(pfl_pkg::ADDR_RESET);
    end else if (!in_load) begin
      half_q <= pfl_pkg::SLOW_HALF;
      hcnt_q <= pfl_pkg::SLOW_HALF;
      config_clock_out_q <= 1'b0;
      addr_q <= ADDR_BITS'(pfl_pkg::ADDR_RESET);
    end else begin
      if (st_sy2_q.rate_valid)
        half_q <= half_of(rate_sy2_q);
      if (rise || fall) begin
        config_clock_out_q <= ~config_clock_out_q;
        hcnt_q <= half_q - 1'b1;
      end else if (hcnt_q != '0) begin
        hcnt_q <= hcnt_q - 1'b1;
      end
      if (fall)
        addr_q <= addr_q + 1'b1;
    end
  end

  // two-entry buffer between the fetch and the serialiser
  logic [pfl_pkg::BYTE_W-1:0] mem_q [FIFO_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic req_q;
  logic [1:0] ack_sy_q;
  logic [pfl_pkg::BYTE_W-1:0] tx_q;
  wire hs_idle = (req_q == ack_sy_q[1]);
  wire fifo_empty = (cnt_q == '0);
  // no hand-over while flushing, so a stale byte never follows a restart
  wire pop = hs_idle && !fifo_empty && (state_q != pfl_pkg::PFL_IDLE);
  always_ff @(posedge clk) begin
    if (rise)
      mem_q[wp_q] <= data_sy2_q;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      req_q <= 1'b0;
      tx_q <= '0;
    end else begin
      if (state_q == pfl_pkg::PFL_IDLE) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
      end else begin
        if (rise)
          wp_q <= wp_q + 1'b1;
        if (pop)
          rp_q <= rp_q + 1'b1;
        cnt_q <= cnt_q + (PW+1)'(rise) - (PW+1)'(pop);
      end
      if (pop) begin
        tx_q <= mem_q[rp_q];
        req_q <= ~req_q;
      end
    end
  end

  // serialiser on the fast clock
  logic [1:0] req_sy_q;
  logic ack_q;
  logic [pfl_pkg::BYTE_W-1:0] sh_q;
  logic [3:0] bits_q;
  wire take = (req_sy_q[1] != ack_q) && (bits_q == 4'h0);
  always_ff @(posedge cfg_shift_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_sy_q <= 2'h0;
      ack_q <= 1'b0;
      sh_q <= '0;
      bits_q <= 4'h0;
      cfg_bit <= 1'b0;
      cfg_bit_valid <= 1'b0;
    end else begin
      req_sy_q <= {req_sy_q[0], req_q};
      cfg_bit_valid <= 1'b0;
      if (take) begin
        sh_q <= tx_q;
        ack_q <= req_sy_q[1];
        bits_q <= pfl_pkg::BIT_COUNT;
      end else if (bits_q != 4'h0 && cfg_ready) begin
        cfg_bit <= sh_q[pfl_pkg::BYTE_W-1];
        cfg_bit_valid <= 1'b1;
        sh_q <= {sh_q[pfl_pkg::BYTE_W-2:0], 1'b0};
        bits_q <= bits_q - 4'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      ack_sy_q <= 2'h0;
    else
      ack_sy_q <= {ack_sy_q[0], ack_q};
  end

  // pin drive, all from flops
  // idle holds init low too, so no release glitch shows between program and clearing
  wire init_low = (state_q == pfl_pkg::PFL_IDLE) || (state_q == pfl_pkg::PFL_CLEAR)
                  || (state_q == pfl_pkg::PFL_FAIL) || !prog_hi;
  wire done_rel = (state_q == pfl_pkg::PFL_DONE);
  wire io_hiz = !prog_hi;
  wire clk_kept = done_rel && keep_sy_q[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_out <= 1'b0;
      init_oe_n <= 1'b0;
      done_out <= 1'b0;
      done_oe_n <= 1'b0;
      config_clock_out <= 1'b0;
      config_clock_oe_n <= 1'b1;
      flash_addr <= '0;
      flash_addr_oe_n <= 1'b1;
      flash_ctl <= '1;
      flash_ctl_oe_n <= 1'b1;
      loading <= 1'b0;
    end else begin
      init_out <= 1'b0;
      init_oe_n <= !init_low;
      done_out <= 1'b0;
      done_oe_n <= done_rel;
      config_clock_out <= config_clock_out_q;
      config_clock_oe_n <= io_hiz || (done_rel && !clk_kept);
      flash_addr <= addr_q;
      flash_addr_oe_n <= io_hiz || !in_load;
      flash_ctl.chip_enable <= 1'b0;
      flash_ctl.output_enable <= 1'b0;
      flash_ctl.write_enable <= 1'b1;
      flash_ctl_oe_n <= io_hiz || !in_load;
      loading <= in_load && done_sy_q[1] == 1'b0;
    end
  end
endmodule

/* File: pfl_loader_sva.sv */
module pfl_loader_sva #(
  parameter int unsigned ADDR_BITS = 24,
  parameter int unsigned FIFO_DEPTH = 2,
  parameter int unsigned CLEAR_CYCLES = 64
) (
  // clocks, reset and board pins
  input wire logic clk, arst_n, cfg_shift_clk, program_request_n, keep_interface,
  input wire logic [2:0] mode_pins, mode_latched,
  input wire logic init_in, init_out, init_oe_n, done_in, done_out, done_oe_n,
  // flash and clock pins
  input wire logic config_clock_out, config_clock_oe_n, flash_addr_oe_n, flash_ctl_oe_n,
  input wire logic [ADDR_BITS-1:0] flash_addr,
  input wire pfl_pkg::pfl_flash_ctl_s flash_ctl,
  input wire logic [7:0] flash_data_in,
  // configuration engine
  input wire pfl_pkg::pfl_cfg_status_s cfg_status,
  input wire logic [3:0] config_clock_rate_setting,
  input wire logic cfg_ready, cfg_bit, cfg_bit_valid, loading
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  load_pins_a: assert property (
    loading |-> flash_ctl == 3'b001 && !flash_ctl_oe_n && !done_oe_n && !config_clock_oe_n)
    else $error("pin levels wrong while loading");
  // pin is registered one cycle after the internal edge
  addr_fall_a: assert property (
    loading && $changed(flash_addr) |-> ##[0:1] !config_clock_out)
    else $error("address moved off the falling clock");
  addr_step_a: assert property (
    loading && $past(loading) && $changed(flash_addr) |-> flash_addr == $past(flash_addr) + 1'b1)
    else $error("address did not step by one byte");
  slow_start_a: assert property (
    $rose(loading) |-> !config_clock_out [*8]) else $error("load did not start slow");
  prog_hiz_a: assert property (
    !program_request_n [*5] |-> flash_addr_oe_n && flash_ctl_oe_n && config_clock_oe_n)
    else $error("pins driven while program low");
  clear_init_a: assert property (
    $rose(program_request_n) |-> !init_oe_n [*8]) else $error("init not low in clearing");
  crc_stop_a: assert property (
    loading && cfg_status.crc_error |-> ##[1:10] !init_oe_n ##10 (!done_oe_n && !loading))
    else $error("crc error not handled");
  done_rel_a: assert property (
    loading && cfg_status.load_end |-> ##[1:10] (done_oe_n && flash_ctl_oe_n))
    else $error("done or flash pins not released");
  cover property ($rose(done_oe_n));
  cover property ($fell(init_oe_n) && !loading);
  cover property (loading && $rose(config_clock_out));
endmodule
bind pfl_loader pfl_loader_sva #(.ADDR_BITS(ADDR_BITS), .FIFO_DEPTH(FIFO_DEPTH),
  .CLEAR_CYCLES(CLEAR_CYCLES)) u_sva (.*);

/* File: pfl_flash_model.sv */
module pfl_flash_model #(
  parameter int unsigned ACC_CYC = 2
) (
  // pins from the loader
  input wire logic clk,
  input wire logic [23:0] flash_addr,
  input wire logic flash_addr_oe_n,
  input wire pfl_pkg::pfl_flash_ctl_s flash_ctl,
  input wire logic flash_ctl_oe_n,
  // data lines back
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] addr_q;
  logic [3:0] age_q = 4'h0;
  wire sel = !flash_ctl_oe_n && !flash_addr_oe_n && flash_ctl == 3'b001;
  wire settled = sel && addr_q == flash_addr && age_q >= ACC_CYC;
  initial data_out = 8'h00;
  always @(posedge clk) begin
    addr_q <= flash_addr;
    age_q <= (addr_q != flash_addr) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    // unselected or mid-access lines toggle so a stale byte is never mistaken for data
    data_out <= settled ? flash_addr[7:0] * 8'h1D + 8'h5A : ~data_out;
  end
endmodule

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  logic clk = 0, cfg_shift_clk = 0, cfg_ready = 1'b1;
  logic arst_n, program_request_n, keep_interface, init_out, init_oe_n, done_out, done_oe_n;
  logic config_clock_out, config_clock_oe_n, flash_addr_oe_n, flash_ctl_oe_n;
  logic cfg_bit, cfg_bit_valid, loading;
  logic [2:0] mode_pins, mode_latched, mode;
  logic [23:0] flash_addr;
  logic [3:0] config_clock_rate_setting;
  logic [7:0] flash_data_in, sh, eb;
  pfl_pkg::pfl_flash_ctl_s flash_ctl;
  pfl_pkg::pfl_cfg_status_s cfg_status;
  // board pull-ups on the two open-drain pins
  wire init_in = init_oe_n ? 1'b1 : init_out;
  wire done_in = done_oe_n ? 1'b1 : done_out;
  int mismatches, comparisons, seed, nbits, nbytes, base, n, hexp;
  logic [7:0] exp_q[$];
  always #12.5 clk = ~clk;
  always #24 cfg_shift_clk = ~cfg_shift_clk;
  pfl_loader u_dut (.*);
  pfl_flash_model u_flash (.clk(clk), .flash_addr(flash_addr), .flash_addr_oe_n(flash_addr_oe_n),
    .flash_ctl(flash_ctl), .flash_ctl_oe_n(flash_ctl_oe_n), .data_out(flash_data_in));
  function automatic logic [7:0] fbyte(input int a);
    return a[7:0] * 8'h1D + 8'h5A;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // clk cycles the clock pin stays high; the high phase is never stretched by a full buffer
  task automatic high_time(output int h);
    for (h = 0; h < 300 && config_clock_out !== 1'b0; h++) tick(1);
    for (h = 0; h < 300 && config_clock_out !== 1'b1; h++) tick(1);
    for (h = 0; h < 300 && config_clock_out === 1'b1; h++) tick(1);
  endtask
  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // random stalls by the serial receiver keep the two-entry buffer filling up
  always @(posedge cfg_shift_clk) cfg_ready <= #2 (($random(seed) & 3) != 0);
  always @(posedge cfg_shift_clk) begin
    if (program_request_n !== 1'b1) nbits = 0;
    else if (cfg_bit_valid === 1'b1) begin
      sh = {sh[6:0], cfg_bit};
      nbits++;
      if (nbits == 8) begin
        nbits = 0;
        nbytes++;
        eb = exp_q.pop_front();
        `CK("serial byte", eb, sh)
      end
    end
  end
  initial begin
    seed = 39615;
    arst_n = 0;
    program_request_n = 1;
    keep_interface = 0;
    mode_pins = 0;
    cfg_status = '0;
    config_clock_rate_setting = 0;
    tick(3);
    arst_n = 1;
    for (int p = 0; p < 3; p++) begin
      mode = 3'($random(seed));
      // later passes let the serialiser drain the previous load first
      tick(p == 0 ? 4 : 200);
      program_request_n = 0;
      mode_pins = mode;
      keep_interface = p[1];
      cfg_status = '0;
      exp_q.delete();
      for (int i = 0; i < 64; i++) exp_q.push_back(fbyte(i));
      tick(5);
      `CK("io hi-z", 3'b111, {flash_addr_oe_n, config_clock_oe_n, flash_ctl_oe_n})
      tick(20);
      program_request_n = 1;
      for (n = 0; n < 400 && loading !== 1'b1; n++) tick(1);
      `CK("mode", mode, mode_latched)
      `CK("ctl", 4'h1, {flash_ctl_oe_n, flash_ctl})
      `CK("first addr", 24'h0, flash_addr)
      base = nbytes;
      for (n = 0; n < 2000 && nbytes < base + 3; n++) tick(1);
      high_time(n);
      `CK("slow half", pfl_pkg::SLOW_HALF, n)
      // rate kept at 6 or below: the model flash needs about 50 ns
      config_clock_rate_setting = 4'(1 + ($random(seed) & 32'hFF) % 6);
      cfg_status.rate_valid = 1;
      for (n = 0; n < 4000 && nbytes < base + 23; n++) tick(1);
      `CK("bytes", 1'b1, nbytes >= base + 23)
      hexp = (config_clock_rate_setting > 4'h1) ? pfl_pkg::SLOW_HALF / config_clock_rate_setting
        : pfl_pkg::SLOW_HALF;
      high_time(n);
      `CK("fast half", hexp, n)
      if (p == 1) begin
        cfg_status.crc_error = 1;
        tick(200);
        `CK("crc stop", 5'h00, {init_oe_n, done_oe_n, loading, init_out, done_out})
      end else begin
        cfg_status.load_end = 1;
        for (n = 0; n < 100 && done_oe_n !== 1'b1; n++) tick(1);
        `CK("done pins", 3'b111, {done_oe_n, flash_ctl_oe_n, flash_addr_oe_n})
        `CK("clock pin", ~keep_interface, config_clock_oe_n)
      end
    end
    summarize();
  end
  initial begin
    // three passes need well under 20000 cycles
    #600000;
    mismatches++;
    summarize();
  end
endmodule
